// ==== hdl/twi_pkg.sv ====
// shared constants and types for the two-wire controller send-mode block
`default_nettype none
package twi_pkg;
	// =====================================================================
	// timing
	localparam int         CLK_MHZ      = 20;
	localparam int         QUARTER_NS   = 500;
	// least time: round up to whole cycles
	localparam int         QUARTER_CYC  = (QUARTER_NS * CLK_MHZ + 999) / 1000;
	localparam logic [7:0] QUARTER_LAST = 8'(QUARTER_CYC - 1);
	// =====================================================================
	// status codes, low three bits always zero
	localparam logic [7:0] CODE_START     = 8'h08;
	localparam logic [7:0] CODE_RESTART   = 8'h10;
	localparam logic [7:0] CODE_ADDR_ACK  = 8'h18;
	localparam logic [7:0] CODE_ADDR_NACK = 8'h20;
	localparam logic [7:0] CODE_DATA_ACK  = 8'h28;
	localparam logic [7:0] CODE_DATA_NACK = 8'h30;
	localparam logic [7:0] CODE_ARB_LOST  = 8'h38;
	localparam logic [7:0] CODE_NONE      = 8'hF8;
	// =====================================================================
	// reset values and sizes
	localparam logic [7:0] DATA_RESET = 8'hFF;
	localparam logic [3:0] ACK_SLOT   = 4'h8;
	localparam int         DATA_W     = 8;
	localparam int         FIFO_DEPTH = 4;
	// =====================================================================
	// types
	typedef enum {S_IDLE, S_WAIT_FREE, S_START, S_BIT, S_HOLD, S_STOP, S_HANDOFF} fsm_t;
	typedef struct packed {
		logic start;
		logic stop;
		logic flag_clear;
		logic ack_en;
	} ctl_t;
	typedef struct packed {
		logic scl;
		logic sda;
	} line_t;
endpackage

`default_nettype wire

// ==== hdl/i2c_master_transmit_status_fsm.sv ====
// two-wire controller send-mode status machine with its transmit byte queue
// Notes on behaviour
// RULE1: start sent: flag set, code 0x08
// RULE2: repeated start sent: flag set, code 0x10
// RULE3: after start, flag clear sends address, samples ack
// RULE4: read address sent, then hand to receiver
// RULE5: address acknowledged: flag set, code 0x18
// RULE6: address not acknowledged: flag set, code 0x20
// RULE7: data acknowledged: flag set, code 0x28
// RULE8: data not acknowledged: flag set, code 0x30
// RULE9: arbitration lost sending: flag set, code 0x38
// RULE10: in completion codes, flag clear sends next byte
// RULE11: start with flag clear gives repeated start
// RULE12: stop with flag clear sends stop, self-clears
// RULE13: start plus stop: stop then start
// RULE14: lost, plain clear: release bus, go idle
// RULE15: lost, start: wait bus free, then start
// RULE16: software masks low status bits before compare
// RULE17: transfer held while done flag set
// RULE18: data write with flag low dropped, collision
`timescale 1ns/1ns
`default_nettype none

module twi_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 4
) (
	input  wire logic         clk,
	input  wire logic         reset,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data,
	output logic              full
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [W-1:0]  mem_reg [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0]   count_reg;
	logic          full_reg;
	logic          empty_reg;
	wire           push = in_valid && !full_reg;
	wire           pop  = out_ready && !empty_reg;
	wire [AW:0]    count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);

	function automatic logic [AW-1:0] wrap(input logic [AW-1:0] p);
		wrap = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	assign in_ready  = !full_reg;
	assign out_valid = !empty_reg;
	assign out_data  = mem_reg[rd_ptr_reg];
	assign full      = full_reg;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
			full_reg   <= 1'b0;
			empty_reg  <= 1'b1;
		end else begin
			if (push) wr_ptr_reg <= wrap(wr_ptr_reg);
			if (pop) rd_ptr_reg <= wrap(rd_ptr_reg);
			count_reg <= count_next;
			full_reg  <= (count_next == (AW+1)'(DEPTH));
			empty_reg <= (count_next == '0);
		end
	end

	always_ff @(posedge clk) begin
		if (push) mem_reg[wr_ptr_reg] <= in_data;
	end
endmodule

module i2c_master_transmit_status_fsm (
	input  wire logic           clk,
	input  wire logic           reset,
	input  wire logic           ctl_wr,
	input  wire twi_pkg::ctl_t  ctl,
	input  wire logic           data_wr,
	input  wire logic [7:0]     data_in,
	input  wire twi_pkg::line_t line_in,
	output wire twi_pkg::line_t line_out,
	output wire twi_pkg::line_t line_oe,
	output wire logic [7:0]     bus_status_register,
	output wire logic [7:0]     bus_data_register,
	output wire logic           transfer_done,
	output wire logic           write_collision_flag,
	output wire logic           halt_request_bit,
	output wire logic           begin_condition_bit,
	output wire logic           ack_enable_bit,
	output wire logic           controller_receive_mode,
	output wire logic           data_full
);
	// =====================================================================
	// state
	twi_pkg::fsm_t state_reg, state_next;
	logic [7:0] q_reg, q_next, status_reg, status_next, shift_reg, shift_next;
	logic [7:0] data_hold_reg, data_hold_next;
	logic [1:0] ph_reg, ph_next;
	logic [3:0] bit_cnt_reg, bit_cnt_next;
	logic is_addr_reg, is_addr_next, rd_reg, rd_next, owned_reg, owned_next;
	logic restart_reg, restart_next, scl_drv_reg, scl_drv_next, sda_drv_reg, sda_drv_next;
	logic flag_reg, flag_next, coll_reg, coll_next, halt_reg, halt_next;
	logic begin_reg, begin_next, ack_en_reg, ack_en_next, rx_mode_reg, rx_mode_next;
	logic busy_reg, scl_m, scl_s, sda_m, sda_s, sda_d, pop;
	logic fifo_valid, fifo_full;
	logic [7:0] fifo_data;

	function automatic logic done_code(input logic [7:0] s);
		done_code = (s == twi_pkg::CODE_ADDR_ACK) || (s == twi_pkg::CODE_ADDR_NACK) ||
			(s == twi_pkg::CODE_DATA_ACK) || (s == twi_pkg::CODE_DATA_NACK);
	endfunction

	function automatic logic addr_code(input logic [7:0] s);
		addr_code = (s == twi_pkg::CODE_START) || (s == twi_pkg::CODE_RESTART);
	endfunction

	// =====================================================================
	// decode
	wire timed     = (state_reg == twi_pkg::S_START) || (state_reg == twi_pkg::S_BIT) ||
		(state_reg == twi_pkg::S_STOP);
	// a target holding the clock low stretches the high phases
	wire stretch   = ph_reg[1] && !scl_drv_reg && !scl_s;
	wire tick      = timed && !stretch && (q_reg == twi_pkg::QUARTER_LAST);
	wire bit_end   = tick && (ph_reg == 2'd3);
	wire ack_end   = bit_end && (state_reg == twi_pkg::S_BIT) && (bit_cnt_reg == twi_pkg::ACK_SLOT);
	wire lost      = bit_end && (state_reg == twi_pkg::S_BIT) && (bit_cnt_reg != twi_pkg::ACK_SLOT) &&
		!sda_drv_reg && !sda_s;
	wire clear_wr  = ctl_wr && ctl.flag_clear;
	wire in_hold   = (state_reg == twi_pkg::S_HOLD) && clear_wr;
	wire [7:0] next_byte = fifo_valid ? fifo_data : data_hold_reg;
	wire accept_wr = data_wr && flag_reg;

	twi_fifo #(.W(twi_pkg::DATA_W), .DEPTH(twi_pkg::FIFO_DEPTH)) i_twi_fifo (
		.clk       (clk),
		.reset     (reset),
		.in_valid  (accept_wr),
		.in_ready  (),
		.in_data   (data_in),
		.out_valid (fifo_valid),
		.out_ready (pop),
		.out_data  (fifo_data),
		.full      (fifo_full)
	);

	assign line_out               = '0;
	assign line_oe                = '{scl: scl_drv_reg, sda: sda_drv_reg};
	assign bus_status_register    = status_reg;
	assign bus_data_register      = data_hold_reg;
	assign transfer_done          = flag_reg;
	assign write_collision_flag   = coll_reg;
	assign halt_request_bit       = halt_reg;
	assign begin_condition_bit    = begin_reg;
	assign ack_enable_bit         = ack_en_reg;
	assign controller_receive_mode = rx_mode_reg;
	assign data_full              = fifo_full;

	// =====================================================================
	// next state
	always_comb begin
		state_next = state_reg;
		q_next = timed && !tick && !stretch ? q_reg + 8'h01 : (stretch ? q_reg : 8'h00);
		ph_next = tick ? ph_reg + 2'd1 : ph_reg;
		status_next = status_reg;
		shift_next = shift_reg;
		data_hold_next = data_hold_reg;
		bit_cnt_next = bit_cnt_reg;
		is_addr_next = is_addr_reg;
		rd_next = rd_reg;
		owned_next = owned_reg;
		restart_next = restart_reg;
		scl_drv_next = scl_drv_reg;
		sda_drv_next = sda_drv_reg;
		rx_mode_next = rx_mode_reg;
		halt_next = halt_reg;
		pop = 1'b0;
		flag_next = clear_wr ? 1'b0 : flag_reg;
		// a write with the flag low is refused; a later good write clears it
		coll_next = (data_wr && !flag_reg) ? 1'b1 : (accept_wr ? 1'b0 : coll_reg); // [RULE18]
		unique case (state_reg)
			twi_pkg::S_IDLE: begin
				if (ctl_wr && ctl.start) state_next = twi_pkg::S_WAIT_FREE;
			end
			twi_pkg::S_WAIT_FREE: begin
				ph_next = 2'd0;
				if (!busy_reg) state_next = twi_pkg::S_START; // [RULE15]
			end
			twi_pkg::S_START: begin
				if (tick) begin
					unique case (ph_reg)
						2'd0: scl_drv_next = 1'b0;
						2'd1: sda_drv_next = 1'b1;
						2'd2: scl_drv_next = 1'b1;
						2'd3: begin
							flag_next = 1'b1;
							status_next = owned_reg ? twi_pkg::CODE_RESTART : twi_pkg::CODE_START; // [RULE1] [RULE2]
							owned_next = 1'b1;
							state_next = twi_pkg::S_HOLD;
						end
					endcase
				end
			end
			twi_pkg::S_BIT: begin
				if (tick) begin
					unique case (ph_reg)
						// data changes only while the clock is low
						2'd0: sda_drv_next = (bit_cnt_reg == twi_pkg::ACK_SLOT) ? 1'b0 : !shift_reg[7];
						2'd1: scl_drv_next = 1'b0;
						2'd2: ;
						2'd3: begin
							scl_drv_next = 1'b1;
							shift_next = {shift_reg[6:0], 1'b0};
							bit_cnt_next = bit_cnt_reg + 4'h1;
							if (lost) begin
								scl_drv_next = 1'b0;
								sda_drv_next = 1'b0;
								owned_next = 1'b0;
								flag_next = 1'b1;
								status_next = twi_pkg::CODE_ARB_LOST; // [RULE9]
								state_next = twi_pkg::S_HOLD;
							end else if (ack_end && is_addr_reg && rd_reg) begin
								rx_mode_next = 1'b1; // [RULE4]
								state_next = twi_pkg::S_HANDOFF;
							end else if (ack_end) begin
								flag_next = 1'b1;
								state_next = twi_pkg::S_HOLD;
								if (is_addr_reg)
									status_next = sda_s ? twi_pkg::CODE_ADDR_NACK : twi_pkg::CODE_ADDR_ACK; // [RULE5] [RULE6]
								else
									status_next = sda_s ? twi_pkg::CODE_DATA_NACK : twi_pkg::CODE_DATA_ACK; // [RULE7] [RULE8]
							end
						end
					endcase
				end
			end
			twi_pkg::S_HOLD: begin
				// the bus stays frozen, clock held low (released after a lost arbitration), until the flag is cleared
				ph_next = 2'd0; // [RULE17]
				if (in_hold) begin
					status_next = twi_pkg::CODE_NONE;
					if (status_reg == twi_pkg::CODE_ARB_LOST) begin
						state_next = ctl.start ? twi_pkg::S_WAIT_FREE : twi_pkg::S_IDLE; // [RULE14] [RULE15]
					end else if (done_code(status_reg) && ctl.stop) begin
						restart_next = ctl.start; // [RULE12] [RULE13]
						sda_drv_next = 1'b1;
						state_next = twi_pkg::S_STOP;
					end else if (done_code(status_reg) && ctl.start) begin
						state_next = twi_pkg::S_START; // [RULE11]
					end else if (addr_code(status_reg) || done_code(status_reg)) begin
						pop = fifo_valid;
						data_hold_next = next_byte;
						shift_next = next_byte;
						bit_cnt_next = 4'h0;
						is_addr_next = addr_code(status_reg); // [RULE3] [RULE10]
						rd_next = next_byte[0];
						state_next = twi_pkg::S_BIT;
					end
				end
			end
			twi_pkg::S_STOP: begin
				if (tick) begin
					unique case (ph_reg)
						2'd0: ;
						2'd1: scl_drv_next = 1'b0;
						2'd2: sda_drv_next = 1'b0;
						2'd3: begin
							owned_next = 1'b0;
							halt_next = 1'b0; // [RULE12]
							state_next = restart_reg ? twi_pkg::S_WAIT_FREE : twi_pkg::S_IDLE; // [RULE13]
						end
					endcase
				end
			end
			twi_pkg::S_HANDOFF: begin
				ph_next = 2'd0;
				if (clear_wr && ctl.stop) begin
					rx_mode_next = 1'b0;
					restart_next = ctl.start;
					sda_drv_next = 1'b1;
					state_next = twi_pkg::S_STOP;
				end
			end
		endcase
		// software writes win over the hardware self-clear
		begin_next = ctl_wr ? ctl.start : begin_reg;
		ack_en_next = ctl_wr ? ctl.ack_en : ack_en_reg;
		if (ctl_wr && ctl.stop) halt_next = 1'b1;
	end

	// =====================================================================
	// registers
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_reg <= twi_pkg::S_IDLE;
			{q_reg, shift_reg} <= '0;
			status_reg <= twi_pkg::CODE_NONE;
			data_hold_reg <= twi_pkg::DATA_RESET;
			{ph_reg, bit_cnt_reg, is_addr_reg, rd_reg, owned_reg, restart_reg} <= '0;
			{scl_drv_reg, sda_drv_reg, flag_reg, coll_reg, halt_reg} <= '0;
			{begin_reg, ack_en_reg, rx_mode_reg} <= '0;
			{scl_m, scl_s, sda_m, sda_s, sda_d, busy_reg} <= 6'h3E;
		end else begin
			state_reg <= state_next;
			{q_reg, shift_reg, status_reg, data_hold_reg} <= {q_next, shift_next, status_next, data_hold_next};
			{ph_reg, bit_cnt_reg, is_addr_reg, rd_reg} <= {ph_next, bit_cnt_next, is_addr_next, rd_next};
			{owned_reg, restart_reg, scl_drv_reg, sda_drv_reg} <= {owned_next, restart_next, scl_drv_next, sda_drv_next};
			{flag_reg, coll_reg, halt_reg} <= {flag_next, coll_next, halt_next};
			{begin_reg, ack_en_reg, rx_mode_reg} <= {begin_next, ack_en_next, rx_mode_next};
			{scl_m, scl_s, sda_m, sda_s, sda_d} <= {line_in.scl, scl_m, line_in.sda, sda_m, sda_s};
			// start and stop seen on the wire mark the bus busy or free
			if (scl_s && sda_d && !sda_s) busy_reg <= 1'b1;
			else if (scl_s && !sda_d && sda_s) busy_reg <= 1'b0;
		end
	end

	// =====================================================================
	// checks
	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	property p_start_code;
		(state_reg == twi_pkg::S_START && bit_end) |=> flag_reg &&
			status_reg == ($past(owned_reg) ? twi_pkg::CODE_RESTART : twi_pkg::CODE_START);
	endproperty
	a_start_code: assert property (p_start_code) else $error("wrong start code"); // [RULE1] [RULE2]

	property p_addr_send;
		(in_hold && addr_code(status_reg) && !ctl.start && !ctl.stop) |=> (state_reg == twi_pkg::S_BIT &&
			is_addr_reg) ##1 !flag_reg [*8];
	endproperty
	a_addr_send: assert property (p_addr_send) else $error("address not sent"); // [RULE3]

	property p_read_switch;
		(ack_end && is_addr_reg && rd_reg && !lost) |=> rx_mode_reg && !flag_reg &&
			state_reg == twi_pkg::S_HANDOFF;
	endproperty
	a_read_switch: assert property (p_read_switch) else $error("no receiver handoff"); // [RULE4]

	property p_addr_code;
		(ack_end && is_addr_reg && !rd_reg) |=> flag_reg &&
			status_reg == ($past(sda_s) ? twi_pkg::CODE_ADDR_NACK : twi_pkg::CODE_ADDR_ACK);
	endproperty
	a_addr_code: assert property (p_addr_code) else $error("wrong address code"); // [RULE5] [RULE6]

	property p_data_code;
		(ack_end && !is_addr_reg) |=> flag_reg &&
			status_reg == ($past(sda_s) ? twi_pkg::CODE_DATA_NACK : twi_pkg::CODE_DATA_ACK);
	endproperty
	a_data_code: assert property (p_data_code) else $error("wrong data code"); // [RULE7] [RULE8]

	property p_lost;
		lost |=> flag_reg && status_reg == twi_pkg::CODE_ARB_LOST && !scl_drv_reg && !sda_drv_reg;
	endproperty
	a_lost: assert property (p_lost) else $error("lost arbitration not reported"); // [RULE9]

	property p_next_action;
		(in_hold && done_code(status_reg)) |=> state_reg == ($past(ctl.stop) ? twi_pkg::S_STOP :
			($past(ctl.start) ? twi_pkg::S_START : twi_pkg::S_BIT));
	endproperty
	a_next_action: assert property (p_next_action) else $error("wrong follow-up action"); // [RULE10] [RULE11]

	property p_stop_end;
		(state_reg == twi_pkg::S_STOP && bit_end && !(ctl_wr && ctl.stop)) |=> !halt_reg &&
			state_reg == ($past(restart_reg) ? twi_pkg::S_WAIT_FREE : twi_pkg::S_IDLE);
	endproperty
	a_stop_end: assert property (p_stop_end) else $error("stop did not finish"); // [RULE12] [RULE13]

	property p_lost_exit;
		(in_hold && status_reg == twi_pkg::CODE_ARB_LOST) |=> !scl_drv_reg && !sda_drv_reg &&
			state_reg == ($past(ctl.start) ? twi_pkg::S_WAIT_FREE : twi_pkg::S_IDLE);
	endproperty
	a_lost_exit: assert property (p_lost_exit) else $error("wrong exit after lost"); // [RULE14] [RULE15]

	property p_hold;
		(flag_reg && !clear_wr) |=> flag_reg && $stable(state_reg) && $stable(line_oe);
	endproperty
	a_hold: assert property (p_hold) else $error("transfer moved while flag set"); // [RULE17]

	property p_collision;
		(data_wr && !flag_reg) |=> coll_reg && $stable(i_twi_fifo.count_reg);
	endproperty
	a_collision: assert property (p_collision) else $error("collision not flagged"); // [RULE18]
endmodule

`default_nettype wire

// ==== dv/twi_target_model.sv ====
// behavioural target receiver for the two-wire link: acks, clock stretch and a competing sender
`timescale 1ns/1ns
`default_nettype none

module twi_target_model (
	input  wire logic  clk,
	input  wire logic  scl,
	input  wire logic  sda,
	input  wire logic  nack_addr,
	input  wire logic  nack_data,
	input  wire logic  stretch,
	input  wire logic  steal,
	output logic       scl_oe,
	output logic       sda_oe,
	output logic [7:0] got
);
	logic       scl_q  = 1'b1;
	logic       sda_q  = 1'b1;
	logic [3:0] cnt    = 4'h0;
	logic       first  = 1'b0;
	logic       ack_oe = 1'b0;
	logic [7:0] sh     = 8'h00;
	int         hold   = 0;

	// =====================================================================
	// open drain: the model only ever pulls low; the bench supplies the pull-ups
	// steal pulls sda low as a competing sender would, to force a lost arbitration
	assign sda_oe = ack_oe | steal;
	assign scl_oe = (hold != 0);

	always @(posedge clk) begin
		scl_q <= scl;
		sda_q <= sda;
		if (hold != 0) begin
			hold <= hold - 1;
		end
		if (scl && scl_q && sda_q && !sda) begin
			cnt    <= 4'h0;
			first  <= 1'b1;
			ack_oe <= 1'b0;
		end else if (scl && scl_q && !sda_q && sda) begin
			cnt    <= 4'h0;
			ack_oe <= 1'b0;
		end else if (scl && !scl_q && cnt < 4'h9) begin
			sh  <= {sh[6:0], sda};
			cnt <= cnt + 4'h1;
			if (cnt == 4'h7) begin
				got <= {sh[6:0], sda};
			end
		end else if (!scl && scl_q) begin
			// holds the clock low for 15 clocks after every falling clock edge
			if (stretch) begin
				hold <= 15;
			end
			if (cnt == 4'h8) begin
				ack_oe <= !(first ? nack_addr : nack_data);
			end
			if (cnt == 4'h9) begin
				ack_oe <= 1'b0;
				cnt    <= 4'h0;
				first  <= 1'b0;
			end
		end
	end
endmodule

`default_nettype wire

// ==== dv/i2c_master_transmit_status_fsm_tb.sv ====
// self-checking bench for the two-wire controller send-mode status machine
`timescale 1ns/1ns
`default_nettype none

module i2c_master_transmit_status_fsm_tb;
	logic           clk       = 1'b0;
	logic           reset     = 1'b1;
	logic           ctl_wr    = 1'b0;
	twi_pkg::ctl_t  ctl       = '0;
	logic           data_wr   = 1'b0;
	logic [7:0]     data_in   = 8'h00;
	logic           nack_addr = 1'b0;
	logic           nack_data = 1'b0;
	logic           stretch   = 1'b0;
	logic           steal     = 1'b0;
	wire twi_pkg::line_t bus;
	wire twi_pkg::line_t dut_oe;
	wire logic [7:0] status;
	wire logic [7:0] dreg;
	wire logic [7:0] got;
	wire logic       done;
	wire logic       wcol;
	wire logic       halt;
	wire logic       rx_mode;
	wire logic       full;
	wire logic       begin_bit;
	wire logic       ack_bit;
	wire twi_pkg::line_t dut_out;
	wire logic       m_scl_oe;
	wire logic       m_sda_oe;
	int              err_count  = 0;
	int              n_compared = 0;
	logic [7:0]      bytes [4]  = '{8'h5A, 8'hC3, 8'h0F, 8'h96};

	always #25 clk = ~clk;

	// =====================================================================
	// wires with pull-ups: low whenever any party enables its driver
	assign bus = '{scl: !(dut_oe.scl | m_scl_oe), sda: !(dut_oe.sda | m_sda_oe)};

	i2c_master_transmit_status_fsm i_i2c_master_transmit_status_fsm (
		.clk                     (clk),
		.reset                   (reset),
		.ctl_wr                  (ctl_wr),
		.ctl                     (ctl),
		.data_wr                 (data_wr),
		.data_in                 (data_in),
		.line_in                 (bus),
		.line_out                (dut_out),
		.line_oe                 (dut_oe),
		.bus_status_register     (status),
		.bus_data_register       (dreg),
		.transfer_done           (done),
		.write_collision_flag    (wcol),
		.halt_request_bit        (halt),
		.begin_condition_bit     (begin_bit),
		.ack_enable_bit          (ack_bit),
		.controller_receive_mode (rx_mode),
		.data_full               (full)
	);

	twi_target_model i_twi_target_model (
		.clk       (clk),
		.scl       (bus.scl),
		.sda       (bus.sda),
		.nack_addr (nack_addr),
		.nack_data (nack_data),
		.stretch   (stretch),
		.steal     (steal),
		.scl_oe    (m_scl_oe),
		.sda_oe    (m_sda_oe),
		.got       (got)
	);

	// =====================================================================
	// access tasks
	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value at %0t ns: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic give_verdict();
		$display("comparisons %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic wr_ctl(input logic st, input logic sp, input logic clr);
		@(posedge clk);
		ctl_wr <= 1'b1;
		ctl    <= '{start: st, stop: sp, flag_clear: clr, ack_en: 1'b1};
		@(posedge clk);
		ctl_wr <= 1'b0;
	endtask

	task automatic wr_data(input logic [7:0] b);
		@(posedge clk);
		data_wr <= 1'b1;
		data_in <= b;
		@(posedge clk);
		data_wr <= 1'b0;
	endtask

	function automatic logic pick(input int w);
		return (w == 0) ? halt : ((w == 1) ? rx_mode : done);
	endfunction

	// first look is a negedge later, so a flag cleared by the last write has landed
	task automatic wait_bit(input int w, input logic v);
		int i;
		@(negedge clk);
		for (i = 0; i < 4000 && pick(w) !== v; i++) begin
			@(negedge clk);
		end
		if (i == 4000) begin
			err_count++;
			$display("wrong value at %0t ns: wait ran out", $time);
			give_verdict();
		end
	endtask

	// status is masked to its code bits before the compare
	task automatic wait_done(input logic [7:0] code);
		wait_bit(2, 1'b1);
		check(status & 8'hF8, code, "status");
	endtask

	task automatic lose_address();
		wr_ctl(1'b1, 1'b0, 1'b1);
		wait_done(8'h08);
		wr_data(8'hA4);
		steal <= 1'b1;
		wr_ctl(1'b0, 1'b0, 1'b1);
		wait_done(8'h38);
		check({6'h00, dut_oe}, 8'h00, "lines after loss");
	endtask

	// =====================================================================
	// main sequence
	initial begin
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		wr_data(8'h11);
		@(negedge clk);
		check({7'h00, wcol}, 8'h01, "collision");
		wr_ctl(1'b1, 1'b0, 1'b1);
		wait_done(8'h08);
		check({6'h00, begin_bit, ack_bit}, 8'h03, "start and ack bits");
		wr_data(8'hA4);
		wr_ctl(1'b0, 1'b0, 1'b1);
		wait_done(8'h18);
		check(got, 8'hA4, "address on wire");
		check({7'h00, begin_bit}, 8'h00, "start bit written low");
		check({7'h00, wcol}, 8'h00, "collision cleared by good write");
		repeat (100) @(negedge clk);
		check({7'h00, dut_oe.scl}, 8'h01, "scl held");
		check(status, 8'h18, "status held");
		// fill the queue past full; the dropped fifth byte must never reach the wire
		for (int k = 0; k < 4; k++) begin
			wr_data(bytes[k]);
		end
		wr_data(8'h77);
		@(negedge clk);
		check({7'h00, full}, 8'h01, "queue full");
		stretch <= 1'b1;
		for (int k = 0; k < 4; k++) begin
			wr_ctl(1'b0, 1'b0, 1'b1);
			wait_done(8'h28);
			check(got, bytes[k], "data on wire");
			check(dreg, bytes[k], "data register");
		end
		nack_data <= 1'b1;
		wr_data(8'h3C);
		wr_ctl(1'b0, 1'b0, 1'b1);
		wait_done(8'h30);
		check(got, 8'h3C, "refused byte");
		nack_data <= 1'b0;
		stretch   <= 1'b0;
		wr_ctl(1'b1, 1'b0, 1'b1);
		wait_done(8'h10);
		nack_addr <= 1'b1;
		wr_data(8'hA6);
		wr_ctl(1'b0, 1'b0, 1'b1);
		wait_done(8'h20);
		nack_addr <= 1'b0;
		wr_ctl(1'b1, 1'b1, 1'b1);
		wait_done(8'h08);
		check({7'h00, halt}, 8'h00, "halt after stop-start");
		wr_data(8'hA4);
		wr_ctl(1'b0, 1'b0, 1'b1);
		wait_done(8'h18);
		wr_ctl(1'b0, 1'b1, 1'b1);
		@(negedge clk);
		check({7'h00, halt}, 8'h01, "halt request");
		wait_bit(0, 1'b0);
		check({6'h00, dut_oe}, 8'h00, "lines after stop");
		lose_address();
		steal <= 1'b0;
		repeat (20) @(posedge clk);
		wr_ctl(1'b0, 1'b0, 1'b1);
		repeat (200) @(negedge clk);
		check({7'h00, done}, 8'h00, "released idle");
		check({6'h00, dut_oe}, 8'h00, "released lines");
		check(status, 8'hF8, "released status");
		check({6'h00, dut_out}, 8'h00, "open drain value");
		// the other sender still holds sda, so the start must wait for the bus to free
		lose_address();
		wr_ctl(1'b1, 1'b0, 1'b1);
		repeat (200) @(negedge clk);
		check({7'h00, done}, 8'h00, "no start while busy");
		check({6'h00, dut_oe}, 8'h00, "waiting lines");
		steal <= 1'b0;
		wait_done(8'h08);
		// a repeated start is only offered after an address or data byte, so send one first
		wr_data(8'hA4);
		wr_ctl(1'b0, 1'b0, 1'b1);
		wait_done(8'h18);
		wr_ctl(1'b1, 1'b0, 1'b1);
		wait_done(8'h10);
		wr_data(8'hA5);
		wr_ctl(1'b0, 1'b0, 1'b1);
		wait_bit(1, 1'b1);
		check(got, 8'hA5, "read address");
		wr_ctl(1'b0, 1'b1, 1'b1);
		wait_bit(0, 1'b0);
		check({7'h00, rx_mode}, 8'h00, "receiver left after stop");
		give_verdict();
	end
endmodule

`default_nettype wire
